// ==== include/rutc_pkg.sv ====
// Constants and types shared by the register update timing control block
package rutc_pkg;
    localparam int RUTC_ADDR_W = 12;
    localparam int RUTC_DATA_W = 28;
    localparam int RUTC_FIELD_W = 16;
    localparam int RUTC_FRAME_BITS = RUTC_ADDR_W + RUTC_DATA_W;
    localparam int RUTC_TGT_W = 6;
    localparam int RUTC_NUM_TGT = 64;
    localparam int RUTC_NUM_CTRL = 8;

    // Group base addresses: front-end, misc, sync generation, timing core
    localparam logic [11:0] RUTC_FRONTEND_BASE = 12'h000;
    localparam logic [11:0] RUTC_MISC_BASE = 12'h010;
    localparam logic [11:0] RUTC_SYNC_GEN_BASE = 12'h020;
    localparam logic [11:0] RUTC_TIMING_CORE_BASE = 12'h030;

    // Update control registers
    localparam logic [11:0] RUTC_FRONTEND_UPDATE_ON_SERIAL_CLOCK = 12'h060;
    localparam logic [11:0] RUTC_FRONTEND_UPDATE_ON_VERTICAL_SYNC = 12'h061;
    localparam logic [11:0] RUTC_MISC_UPDATE_ON_SERIAL_CLOCK = 12'h062;
    localparam logic [11:0] RUTC_MISC_UPDATE_ON_VERTICAL_SYNC = 12'h063;
    localparam logic [11:0] RUTC_SYNC_GEN_UPDATE_ON_SERIAL_CLOCK = 12'h064;
    localparam logic [11:0] RUTC_SYNC_GEN_UPDATE_ON_VERTICAL_SYNC = 12'h065;
    localparam logic [11:0] RUTC_TIMING_CORE_UPDATE_ON_SERIAL_CLOCK = 12'h066;
    localparam logic [11:0] RUTC_TIMING_CORE_UPDATE_ON_VERTICAL_SYNC = 12'h067;
    localparam logic [8:0] RUTC_CTRL_PAGE = 9'h00c;
    localparam logic [5:0] RUTC_TGT_PAGE = 6'h00;

    // Reset values, index 0 is the register at 0x60
    localparam logic [RUTC_NUM_CTRL-1:0][RUTC_FIELD_W-1:0] RUTC_CTRL_RST = {
        16'h0000, 16'hffff, 16'h0006, 16'hfff9, 16'h0702, 16'hf8fd, 16'he7fc, 16'h1803};

    localparam logic [5:0] RUTC_LAST_BIT = 6'h27;
    localparam logic [5:0] RUTC_BIT_SAT = 6'h28;

    typedef struct packed {
        logic valid;
        logic [RUTC_TGT_W-1:0] addr;
        logic [RUTC_DATA_W-1:0] data;
    } rutc_apply_t;
endpackage : rutc_pkg

// ==== verilog/rutc_sync_edge.sv ====
// Two-flop synchroniser with rising edge detect
`timescale 1ns/10ps
`default_nettype none
module rutc_sync_edge (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic din,
    output logic level,
    output logic rise
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (ce) begin
            meta_q <= din;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
endmodule : rutc_sync_edge
`default_nettype wire

// ==== verilog/rutc_top.sv ====
// Register update timing control: serial write port and deferred apply on vertical sync
`timescale 1ns/10ps
`default_nettype none
module rutc_top
    import rutc_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic SCK,
    input wire logic SDATA,
    input wire logic SLOAD_B,
    input wire logic VSYNC,
    output rutc_apply_t APPLY,
    output logic [RUTC_NUM_TGT-1:0] PENDING,
    output logic [RUTC_NUM_CTRL-1:0][RUTC_FIELD_W-1:0] UPD_CTRL
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic sck_rise;
    logic sdata_s;
    logic sload_b_s;
    logic vsync_rise;

    rutc_sync_edge u_sck (.clk(SYS_CLK), .rst_b(RST_B), .ce(CE), .din(SCK), .level(), .rise(sck_rise));
    rutc_sync_edge u_sdata (.clk(SYS_CLK), .rst_b(RST_B), .ce(CE), .din(SDATA), .level(sdata_s), .rise());
    rutc_sync_edge u_sload (.clk(SYS_CLK), .rst_b(RST_B), .ce(CE), .din(SLOAD_B), .level(sload_b_s), .rise());
    rutc_sync_edge u_vsync (.clk(SYS_CLK), .rst_b(RST_B), .ce(CE), .din(VSYNC), .level(), .rise(vsync_rise));

    // Lowest set bit of a mask, with a found flag on top
    function automatic logic [RUTC_TGT_W:0] first_set(input logic [RUTC_NUM_TGT-1:0] m);
        logic [RUTC_TGT_W:0] r;
        r = '0;
        for (int i = RUTC_NUM_TGT - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = {1'b1, RUTC_TGT_W'(i)};
            end
        end
        return r;
    endfunction : first_set

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame: address then data, LSB first, while the load strobe is low
    logic [RUTC_FRAME_BITS-1:0] shift_q;
    logic [5:0] bit_cnt_q;
    logic wr_go_q;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            shift_q <= '0;
            bit_cnt_q <= 6'h00;
            wr_go_q <= 1'b0;
        end else if (CE) begin
            wr_go_q <= 1'b0;
            if (sload_b_s) begin
                bit_cnt_q <= 6'h00;
            end else if (sck_rise && bit_cnt_q != RUTC_BIT_SAT) begin
                // Extra bits past one word are dropped until the strobe rises
                shift_q <= {sdata_s, shift_q[RUTC_FRAME_BITS-1:1]};
                bit_cnt_q <= bit_cnt_q + 6'h01;
                wr_go_q <= (bit_cnt_q == RUTC_LAST_BIT);
            end
        end
    end

    logic [RUTC_ADDR_W-1:0] wr_addr;
    logic [RUTC_DATA_W-1:0] wr_data;
    logic wr_ctrl;
    logic wr_tgt;
    logic [RUTC_TGT_W-1:0] tgt_idx;
    logic [2:0] ctrl_sck_sel;
    logic sck_en;
    logic vsync_en;
    logic wr_defer;

    assign wr_addr = shift_q[RUTC_ADDR_W-1:0];
    assign wr_data = shift_q[RUTC_FRAME_BITS-1:RUTC_ADDR_W];
    assign wr_ctrl = wr_go_q && wr_addr[11:3] == RUTC_CTRL_PAGE;
    assign wr_tgt = wr_go_q && wr_addr[11:6] == RUTC_TGT_PAGE;
    assign tgt_idx = wr_addr[RUTC_TGT_W-1:0];
    // Group in idx[5:4]; serial-clock field at even index, vertical-sync at odd
    assign ctrl_sck_sel = {tgt_idx[5:4], 1'b0};
    assign sck_en = UPD_CTRL[ctrl_sck_sel][tgt_idx[3:0]];
    assign vsync_en = UPD_CTRL[ctrl_sck_sel | 3'h1][tgt_idx[3:0]];
    // Serial-clock enable wins when both are set; neither set applies at once
    assign wr_defer = wr_tgt && !sck_en && vsync_en;

    ////////////////////////////////////////////////////////////////////////////
    // Update control registers
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            UPD_CTRL <= RUTC_CTRL_RST;
        end else if (CE && wr_ctrl) begin
            // Upper bits are expected zero from the host and are not stored
            UPD_CTRL[wr_addr[2:0]] <= wr_data[RUTC_FIELD_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Deferred values and the flush that follows a vertical sync edge
    logic [RUTC_DATA_W-1:0] pend_data [RUTC_NUM_TGT];
    logic [RUTC_NUM_TGT-1:0] flush_mask_q;
    logic [RUTC_TGT_W:0] pick;
    logic flush_take;
    logic [RUTC_DATA_W-1:0] pick_data;

    assign pick = first_set(flush_mask_q);
    // A serial write owns the apply port that cycle; the flush waits one cycle
    assign flush_take = pick[RUTC_TGT_W] && !wr_tgt;
    assign pick_data = pend_data[pick[RUTC_TGT_W-1:0]];

    always_ff @(posedge SYS_CLK) begin
        if (CE && wr_defer) begin
            pend_data[tgt_idx] <= wr_data;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PENDING <= '0;
        end else if (CE) begin
            if (flush_take) begin
                PENDING[pick[RUTC_TGT_W-1:0]] <= 1'b0;
            end
            if (wr_tgt) begin
                PENDING[tgt_idx] <= wr_defer;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            flush_mask_q <= '0;
        end else if (CE) begin
            logic [RUTC_NUM_TGT-1:0] m;
            m = flush_mask_q;
            if (vsync_rise) begin
                m = m | PENDING;
            end
            // The index flushed now is consumed; an edge in the same cycle must not re-arm it
            if (flush_take) begin
                m[pick[RUTC_TGT_W-1:0]] = 1'b0;
            end
            // A value written after the edge waits for the next one
            if (wr_tgt) begin
                m[tgt_idx] = 1'b0;
            end
            flush_mask_q <= m;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Apply port toward the target registers
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            APPLY <= '0;
        end else if (CE) begin
            APPLY.valid <= 1'b0;
            if (wr_tgt && !wr_defer) begin
                APPLY <= {1'b1, tgt_idx, wr_data};
            end else if (flush_take) begin
                APPLY <= {1'b1, pick[RUTC_TGT_W-1:0], pick_data};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B || !CE);

    sequence s_defer_write;
        wr_defer;
    endsequence

    sequence s_flush_start;
        vsync_rise ##1 (flush_mask_q != '0);
    endsequence

    a_sck_immediate: assert property (wr_tgt && sck_en |=> APPLY.valid
        && APPLY.addr == $past(tgt_idx) && APPLY.data == $past(wr_data))
        else $error("serial-clock update not applied");
    a_neither_immediate: assert property (wr_tgt && !sck_en && !vsync_en |=> APPLY.valid
        && !PENDING[$past(tgt_idx)])
        else $error("write with no enable not applied");
    a_defer_hold: assert property (s_defer_write |=> !APPLY.valid && PENDING[$past(tgt_idx)])
        else $error("deferred write applied early");
    a_flush_runs: assert property (s_flush_start |-> ##[0:2] APPLY.valid)
        else $error("vertical sync did not flush");
    a_flush_data: assert property (flush_take |=> APPLY.valid && APPLY.data == $past(pick_data))
        else $error("flushed data wrong");
    a_pend_clear_cause: assert property ((|($past(PENDING) & ~PENDING)) |-> $past(flush_take || wr_tgt))
        else $error("pending bit lost without cause");
    a_apply_cause: assert property (APPLY.valid |-> $past(wr_tgt || flush_take))
        else $error("apply with no cause");
    a_ctrl_write: assert property (wr_ctrl |=> UPD_CTRL[$past(wr_addr[2:0])] == $past(wr_data[15:0]))
        else $error("update control write not immediate");
    a_ctrl_stable: assert property (!wr_ctrl |=> UPD_CTRL == $past(UPD_CTRL))
        else $error("update control changed without write");
    a_bit_count: assert property (wr_go_q |-> $past(bit_cnt_q) == RUTC_LAST_BIT)
        else $error("write taken at wrong bit count");
endmodule : rutc_top
`default_nettype wire

// ==== dv/rutc_host_model.sv ====
// Host controller model driving the three-wire serial port
`timescale 1ns/10ps
`default_nettype none
module rutc_host_model (
    input wire logic clk,
    output logic sck,
    output logic sdata,
    output logic sload_b
);
    initial begin
        sck = 1'b0;
        sdata = 1'b0;
        sload_b = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Address then data, lsb first; the clock stands low outside frames
    task automatic send(input logic [11:0] addr, input logic [27:0] data);
        logic [39:0] word;
        word = {data, addr};
        if (addr >= 12'h060) word[39:28] = 12'h000;
        if (addr >= 12'h068) word[39:12] = 28'h0;
        sload_b <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 40; i++) begin
            sdata <= word[i];
            repeat (8) @(posedge clk);
            sck <= 1'b1;
            repeat (8) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (8) @(posedge clk);
        sload_b <= 1'b1;
        // Released data line must not keep looking valid
        sdata <= ~sdata;
        repeat (8) @(posedge clk);
    endtask : send
endmodule : rutc_host_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the register update timing control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import rutc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic vsync = 1'b0;
    wire logic sck;
    wire logic sdata;
    wire logic sload_b;
    rutc_apply_t apply;
    logic [RUTC_NUM_TGT-1:0] pending;
    logic [RUTC_NUM_CTRL-1:0][RUTC_FIELD_W-1:0] upd_ctrl;
    logic [7:0][15:0] m_ctrl = RUTC_CTRL_RST;
    logic [27:0] m_val [64];
    logic [63:0] m_pend = '0;
    logic [33:0] m_q [$];
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;

    always #2 sys_clk = ~sys_clk;

    rutc_host_model rutc_host_model_inst (.clk(sys_clk), .sck(sck), .sdata(sdata), .sload_b(sload_b));
    rutc_top rutc_top_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .CE(ce), .SCK(sck), .SDATA(sdata),
        .SLOAD_B(sload_b), .VSYNC(vsync), .APPLY(apply), .PENDING(pending), .UPD_CTRL(upd_ctrl));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic cmp(input logic [127:0] exp, input logic [127:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp

    // Expectation is queued before the frame, the apply can land before send returns
    task automatic wr(input logic [11:0] a, input logic [27:0] d);
        int g;
        g = a[5:4];
        if (a < 12'h040) begin
            if (m_ctrl[2*g][a[3:0]] || !m_ctrl[2*g+1][a[3:0]]) begin
                m_q.push_back({a[5:0], d});
                m_pend[a[5:0]] = 1'b0;
            end else begin
                m_val[a[5:0]] = d;
                m_pend[a[5:0]] = 1'b1;
            end
        end else if (a >= 12'h060 && a < 12'h068) m_ctrl[a[2:0]] = d[15:0];
        rutc_host_model_inst.send(a, d);
        repeat (8) @(posedge sys_clk);
        cmp(m_pend, pending);
        cmp(m_ctrl, upd_ctrl);
    endtask : wr

    task automatic vs();
        // An edge that comes and goes while the clock enable is low is lost
        ce <= 1'b0;
        vsync <= 1'b1;
        repeat (8) @(posedge sys_clk);
        vsync <= 1'b0;
        repeat (4) @(posedge sys_clk);
        ce <= 1'b1;
        repeat (8) @(posedge sys_clk);
        cmp(m_pend, pending);
        for (int i = 0; i < 64; i++) if (m_pend[i]) m_q.push_back({6'(i), m_val[i]});
        m_pend = '0;
        vsync <= 1'b1;
        repeat (8) @(posedge sys_clk);
        vsync <= 1'b0;
        repeat (80) @(posedge sys_clk);
        cmp(m_pend, pending);
        cmp(m_q.size(), 0);
    endtask : vs

    ////////////////////////////////////////////////////////////////////////
    // Sampled mid-cycle, where the one-cycle apply pulse has settled
    always @(negedge sys_clk) begin
        cyc <= cyc + 1;
        if (rst_b && apply.valid === 1'b1) begin
            cmp((m_q.size() > 0) ? m_q.pop_front() : 'x, {apply.addr, apply.data});
        end
        if (cyc == 60000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(58327));
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge sys_clk);
        cmp(m_ctrl, upd_ctrl);
        for (int r = 0; r < 3; r++) begin
            if (r > 0) begin
                for (int k = 0; k < 8; k++) wr(12'h060 + 12'(k), 28'($urandom));
                wr(12'h068, 28'h0);
            end
            for (int j = 0; j < 10; j++) wr(12'($urandom_range(63)), 28'($urandom));
            vs();
        end
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
